//--- hw/reset_source_control.sv
// reset source combiner with cause flags, brownout control and axi4-lite
// Contract
// RULE_01 - pin reset disabled only when pin enable and low-voltage config both 0
// RULE_02 - enabled pin held low keeps the device in reset; pin pulled up
// RULE_03 - short low pulses on the pin are filtered out
// RULE_04 - no reset ever drives the pin; it stays an input
// RULE_05 - disabled pin is a plain input with software pull-up control
// RULE_06 - watchdog expiry resets, updates time-out/power-down and its flag
// RULE_07 - reset instruction resets fully and drives its active-low flag to 0
// RULE_08 - stack over/underflow resets when enabled and sets its flag
// RULE_09 - leaving programming mode acts like a device reset
// RULE_10 - power-up delay holds reset 64 ms after power-on or brownout
// RULE_11 - power-up delay active only when its active-low config bit is 0
// RULE_12 - delay count starts once power-on and brownout are released
// RULE_13 - soft brownout enable bit 7 acts only when brownout mode is 01
// RULE_14 - software always writes 0 to reserved bit 6
// RULE_15 - bit 0 reads 1 while brownout circuit active, else 0
// RULE_16 - brownout control bits 5 to 1 read as zero
// RULE_17 - cause register has one flag per reset source
// RULE_18 - a reset changes only its own cause flag
// RULE_19 - hardware never returns a flag to inactive; software does
// RULE_20 - software may set flags active without causing a reset
// RULE_21 - low-power brownout request is ORed into the brownout request
// RULE_22 - pin filter is a synchroniser plus consecutive-low counter
// RULE_23 - system reset is OR of sources and delay, synchronously released
module reset_source_control #(
    parameter int unsigned PUD_CYCLES = rsc_pkg::PUD_DEFAULT_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_master_clear_pin,
    output logic o_master_clear_pin_o,
    output logic o_master_clear_pin_oe,
    output logic o_pin_pullup_en,
    output logic o_pin_gpio_level,
    input wire logic i_master_clear_enable_cfg,
    input wire logic i_low_voltage_prog_cfg,
    input wire logic i_stack_fault_reset_cfg,
    input wire logic i_power_up_delay_cfg_n,
    input wire rsc_pkg::bor_mode_t i_brownout_mode_cfg,
    input wire logic i_sleeping,
    input wire logic i_brownout_det,
    input wire logic i_low_power_brownout_det,
    input wire logic i_watchdog_expire,
    input wire logic i_reset_instr,
    input wire logic i_stack_overflow,
    input wire logic i_stack_underflow,
    input wire logic i_prog_exit,
    output logic o_sys_reset_n,
    input wire logic [rsc_pkg::AXI_ADDR_W-1:0] i_s_awaddr,
    input wire logic i_s_awvalid,
    output logic o_s_awready,
    input wire logic [31:0] i_s_wdata,
    input wire logic [3:0] i_s_wstrb,
    input wire logic i_s_wvalid,
    output logic o_s_wready,
    output logic [1:0] o_s_bresp,
    output logic o_s_bvalid,
    input wire logic i_s_bready,
    input wire logic [rsc_pkg::AXI_ADDR_W-1:0] i_s_araddr,
    input wire logic i_s_arvalid,
    output logic o_s_arready,
    output logic [31:0] o_s_rdata,
    output logic [1:0] o_s_rresp,
    output logic o_s_rvalid,
    input wire logic i_s_rready
);
    import rsc_pkg::*;

    logic pin_low_f;
    logic pin_level_s;
    logic pud_running;
    logic pin_enabled;
    logic pin_req;
    logic bor_en;
    logic bor_req;
    logic stk_ovf_evt;
    logic stk_unf_evt;
    logic pulse_evt;
    logic [HOLD_W-1:0] hold_reg;
    logic [7:0] bor_ctrl_reg;
    logic [7:0] cause_reg;
    logic [7:0] cause_next;
    logic pullup_sw_reg;
    logic timeout_status_reg;
    logic powerdown_status_reg;
    logic [AXI_ADDR_W-1:0] aw_addr_reg;
    logic aw_full_reg;
    logic [7:0] w_data_reg;
    logic w_lane0_reg;
    logic w_full_reg;
    logic wr_fire;
    logic wr_hit_bor;
    logic wr_hit_cause;
    logic wr_hit_pin;
    logic [7:0] rd_byte;
    logic rd_ok;

    pin_filter #(
        .SAMPLES(FILTER_CYCLES)
    ) u_filter (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_pin(i_master_clear_pin),
        .o_low(pin_low_f),
        .o_level(pin_level_s)
    ); // [RULE_03] [RULE_22]

    power_up_timer #(
        .CYCLES(PUD_CYCLES)
    ) u_pud (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_hold(bor_req), // [RULE_12]
        .i_power_up_delay_cfg_n(i_power_up_delay_cfg_n), // [RULE_11]
        .o_running(pud_running)
    ); // [RULE_10]

    assign pin_enabled = i_master_clear_enable_cfg
        || i_low_voltage_prog_cfg; // [RULE_01]
    assign pin_req = pin_enabled && pin_low_f; // [RULE_02]

    always_comb begin
        case (i_brownout_mode_cfg)
            BOR_SOFT: bor_en = bor_ctrl_reg[BOR_SOFT_EN_BIT]; // [RULE_13]
            BOR_NOSLEEP: bor_en = !i_sleeping;
            BOR_ON: bor_en = 1'b1;
            default: bor_en = 1'b0;
        endcase
    end

    assign bor_req = (bor_en && i_brownout_det)
        || i_low_power_brownout_det; // [RULE_21]
    assign stk_ovf_evt = i_stack_fault_reset_cfg && i_stack_overflow;
    assign stk_unf_evt = i_stack_fault_reset_cfg && i_stack_underflow;
    assign pulse_evt = i_watchdog_expire || i_reset_instr || stk_ovf_evt
        || stk_unf_evt || i_prog_exit; // [RULE_06] [RULE_07] [RULE_08]

    // one-cycle events are stretched to a minimum reset length
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hold_reg <= HOLD_LOAD;
        end else if (pulse_evt) begin
            hold_reg <= HOLD_LOAD; // [RULE_09]
        end else if (hold_reg != '0) begin
            hold_reg <= hold_reg - HOLD_W'(1);
        end
    end

    // released on a clock edge, asserted at once by the async reset
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sys_reset_n <= 1'b0;
        end else begin
            o_sys_reset_n <= !(pin_req || bor_req || pud_running
                || pulse_evt || hold_reg > HOLD_W'(1)); // [RULE_23]
        end
    end

    // the pin is never driven by this block
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_master_clear_pin_o <= 1'b0;
            o_master_clear_pin_oe <= 1'b0;
        end else begin
            o_master_clear_pin_o <= 1'b0;
            o_master_clear_pin_oe <= 1'b0; // [RULE_04]
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pin_pullup_en <= 1'b1;
            o_pin_gpio_level <= 1'b1;
        end else begin
            o_pin_pullup_en <= pin_enabled || pullup_sw_reg; // [RULE_05]
            o_pin_gpio_level <= pin_level_s; // [RULE_05]
        end
    end

    assign wr_fire = aw_full_reg && w_full_reg && !o_s_bvalid;
    assign wr_hit_bor = wr_fire && w_lane0_reg
        && aw_addr_reg == BOR_CTRL_OFFSET;
    assign wr_hit_cause = wr_fire && w_lane0_reg
        && aw_addr_reg == CAUSE_OFFSET;
    assign wr_hit_pin = wr_fire && w_lane0_reg
        && aw_addr_reg == PIN_CTRL_OFFSET;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bor_ctrl_reg <= BOR_CTRL_RESET;
        end else if (wr_hit_bor) begin
            bor_ctrl_reg <= w_data_reg & BOR_CTRL_WMASK; // [RULE_16]
        end
    end

    // software value first, then any hardware event on top of it
    always_comb begin
        cause_next = cause_reg;
        if (wr_hit_cause) begin
            cause_next = w_data_reg & CAUSE_IMPL; // [RULE_19] [RULE_20]
        end
        if (bor_req) begin
            cause_next[CAUSE_BOR_BIT] = 1'b0; // [RULE_18]
        end
        if (i_reset_instr) begin
            cause_next[CAUSE_SOFT_BIT] = 1'b0; // [RULE_07]
        end
        if (pin_req) begin
            cause_next[CAUSE_PIN_BIT] = 1'b0; // [RULE_17]
        end
        if (i_watchdog_expire) begin
            cause_next[CAUSE_WDT_BIT] = 1'b0; // [RULE_06]
        end
        if (stk_unf_evt) begin
            cause_next[CAUSE_STACK_UNDER_FLAG_BIT] = 1'b1; // [RULE_08]
        end
        if (stk_ovf_evt) begin
            cause_next[CAUSE_STACK_OVER_FLAG_BIT] = 1'b1; // [RULE_08]
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cause_reg <= CAUSE_RESET;
        end else begin
            cause_reg <= cause_next;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pullup_sw_reg <= PULLUP_RESET;
        end else if (wr_hit_pin) begin
            pullup_sw_reg <= w_data_reg[PIN_PULLUP_BIT];
        end
    end

    // time-out low and power-down high after a watchdog reset
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            timeout_status_reg <= 1'b1;
            powerdown_status_reg <= 1'b1;
        end else if (i_watchdog_expire) begin
            timeout_status_reg <= 1'b0; // [RULE_06]
            powerdown_status_reg <= 1'b1;
        end
    end

    // write channel: address and data taken in either order
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_s_awready <= 1'b1;
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (i_s_awvalid && o_s_awready) begin
            o_s_awready <= 1'b0;
            aw_full_reg <= 1'b1;
            aw_addr_reg <= i_s_awaddr;
        end else if (wr_fire) begin
            aw_full_reg <= 1'b0;
        end else if (o_s_bvalid && i_s_bready) begin
            o_s_awready <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_s_wready <= 1'b1;
            w_full_reg <= 1'b0;
            w_data_reg <= '0;
            w_lane0_reg <= 1'b0;
        end else if (i_s_wvalid && o_s_wready) begin
            o_s_wready <= 1'b0;
            w_full_reg <= 1'b1;
            w_data_reg <= i_s_wdata[7:0];
            w_lane0_reg <= i_s_wstrb[0];
        end else if (wr_fire) begin
            w_full_reg <= 1'b0;
        end else if (o_s_bvalid && i_s_bready) begin
            o_s_wready <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_s_bvalid <= 1'b0;
            o_s_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            o_s_bvalid <= 1'b1;
            o_s_bresp <= (aw_addr_reg == BOR_CTRL_OFFSET
                || aw_addr_reg == CAUSE_OFFSET
                || aw_addr_reg == PIN_CTRL_OFFSET) ? RESP_OKAY : RESP_SLVERR;
        end else if (i_s_bready) begin
            o_s_bvalid <= 1'b0;
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        rd_ok = 1'b1;
        case (i_s_araddr)
            BOR_CTRL_OFFSET: begin
                rd_byte = bor_ctrl_reg;
                rd_byte[BOR_READY_BIT] = bor_en; // [RULE_15]
            end
            CAUSE_OFFSET: rd_byte = cause_reg; // [RULE_17]
            PIN_CTRL_OFFSET: begin
                rd_byte[PIN_PULLUP_BIT] = pullup_sw_reg;
                rd_byte[PIN_LEVEL_BIT] = pin_level_s;
                rd_byte[PIN_TIMEOUT_BIT] = timeout_status_reg;
                rd_byte[PIN_POWERDOWN_BIT] = powerdown_status_reg;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_s_arready <= 1'b1;
            o_s_rvalid <= 1'b0;
            o_s_rdata <= '0;
            o_s_rresp <= RESP_OKAY;
        end else if (i_s_arvalid && o_s_arready) begin
            o_s_arready <= 1'b0;
            o_s_rvalid <= 1'b1;
            o_s_rdata <= {24'h000000, rd_byte};
            o_s_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (o_s_rvalid && i_s_rready) begin
            o_s_rvalid <= 1'b0;
            o_s_arready <= 1'b1;
        end
    end

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);

    a_pin_cfg_table: assert property ( // [RULE_01]
        (!i_master_clear_enable_cfg && !i_low_voltage_prog_cfg)
            |-> !pin_req)
        else $error("pin reset active while disabled");
    a_pin_holds_reset: assert property ( // [RULE_02]
        pin_req |=> !o_sys_reset_n)
        else $error("enabled low pin did not hold reset");
    a_pin_short_pulse: assert property ( // [RULE_03]
        $rose(pin_low_f) |-> $past(!i_master_clear_pin, 3)
            && $past(!i_master_clear_pin, 11))
        else $error("filter passed a short pulse");
    a_pin_never_driven: assert property ( // [RULE_04]
        !o_master_clear_pin_oe)
        else $error("master clear pin driven");
    a_wdt_reset: assert property ( // [RULE_06]
        i_watchdog_expire |=> !cause_reg[CAUSE_WDT_BIT]
            && !timeout_status_reg && !o_sys_reset_n)
        else $error("watchdog reset not recorded");
    a_soft_reset: assert property ( // [RULE_07]
        i_reset_instr |=> !cause_reg[CAUSE_SOFT_BIT]
            ##0 !o_sys_reset_n [*8])
        else $error("reset instruction not taken");
    a_stack_reset: assert property ( // [RULE_08]
        (i_stack_fault_reset_cfg && i_stack_overflow)
            |=> cause_reg[CAUSE_STACK_OVER_FLAG_BIT] && !o_sys_reset_n)
        else $error("stack overflow reset missing");
    a_prog_exit_reset: assert property ( // [RULE_09]
        i_prog_exit |=> !o_sys_reset_n [*8])
        else $error("programming exit did not reset");
    a_pud_after_bor: assert property ( // [RULE_10] [RULE_12]
        ($fell(bor_req) && !i_power_up_delay_cfg_n)
            |=> !o_sys_reset_n [*8])
        else $error("power-up delay not applied");
    a_pud_disabled: assert property ( // [RULE_11]
        ($past(i_power_up_delay_cfg_n) && $past(i_reset_n))
            |-> !pud_running)
        else $error("power-up delay ran while disabled");
    a_soft_bor_enable: assert property ( // [RULE_13]
        (i_brownout_mode_cfg == BOR_SOFT && !i_low_power_brownout_det)
            |-> bor_req
            == (bor_ctrl_reg[BOR_SOFT_EN_BIT] && i_brownout_det))
        else $error("soft brownout enable ignored");
    a_bor_readback: assert property ( // [RULE_15] [RULE_16]
        (i_s_arvalid && o_s_arready && i_s_araddr == BOR_CTRL_OFFSET)
            |=> o_s_rdata[5:1] == 5'h00
            && o_s_rdata[0] == $past(bor_en))
        else $error("brownout control readback wrong");
    a_flags_sticky: assert property ( // [RULE_18] [RULE_19]
        !$past(wr_hit_cause) |-> ((cause_reg ^ $past(cause_reg))
            & (cause_reg ^ CAUSE_ACTIVE) & CAUSE_IMPL) == 8'h00)
        else $error("hardware returned a flag to inactive");
    a_flag_write_quiet: assert property ( // [RULE_20]
        (wr_hit_cause && !pulse_evt && !pin_req && !bor_req
            && !pud_running && hold_reg <= HOLD_W'(1))
            |=> o_sys_reset_n)
        else $error("flag write caused a reset");
endmodule

//--- hw/rsc_pkg.sv
// constants, register map and types for the reset source controller
package rsc_pkg;
    localparam int unsigned CLK_FREQ_KHZ = 125000;
    localparam int unsigned CLK_PERIOD_NS = 8;
    // power-up delay, nominal
    localparam int unsigned PUD_TIME_MS = 64;
    localparam int unsigned PUD_DEFAULT_CYCLES = PUD_TIME_MS * CLK_FREQ_KHZ;
    // longest low pulse on the pin that is still filtered out
    localparam int unsigned FILTER_TIME_NS = 64;
    localparam int unsigned FILTER_CYCLES =
        (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // least reset length after a one-cycle reset event
    localparam int unsigned HOLD_TIME_NS = 128;
    localparam int unsigned HOLD_CYCLES =
        (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_W = $clog2(HOLD_CYCLES + 1);
    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYCLES);

    localparam int unsigned AXI_ADDR_W = 8;
    localparam logic [7:0] BOR_CTRL_OFFSET = 8'h00;
    localparam logic [7:0] CAUSE_OFFSET = 8'h04;
    localparam logic [7:0] PIN_CTRL_OFFSET = 8'h08;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // brownout control register
    localparam int unsigned BOR_SOFT_EN_BIT = 7;
    localparam int unsigned BOR_RESERVED_BIT = 6;
    localparam int unsigned BOR_READY_BIT = 0;
    localparam logic [7:0] BOR_CTRL_RESET = 8'h80;
    localparam logic [7:0] BOR_CTRL_WMASK = 8'hc0;

    // reset cause register; a one in CAUSE_ACTIVE marks an active-high flag
    localparam int unsigned CAUSE_POR_BIT = 0;
    localparam int unsigned CAUSE_BOR_BIT = 1;
    localparam int unsigned CAUSE_SOFT_BIT = 2;
    localparam int unsigned CAUSE_PIN_BIT = 3;
    localparam int unsigned CAUSE_WDT_BIT = 4;
    localparam int unsigned CAUSE_STACK_UNDER_FLAG_BIT = 6;
    localparam int unsigned CAUSE_STACK_OVER_FLAG_BIT = 7;
    localparam logic [7:0] CAUSE_ACTIVE = 8'hc0;
    localparam logic [7:0] CAUSE_IMPL = 8'hdf;
    localparam logic [7:0] CAUSE_RESET = 8'h1e;

    // pin control and status register
    localparam int unsigned PIN_PULLUP_BIT = 0;
    localparam int unsigned PIN_LEVEL_BIT = 1;
    localparam int unsigned PIN_TIMEOUT_BIT = 2;
    localparam int unsigned PIN_POWERDOWN_BIT = 3;
    localparam logic PULLUP_RESET = 1'b1;

    typedef enum logic [1:0] {
        BOR_OFF = 2'b00,
        BOR_SOFT = 2'b01,
        BOR_NOSLEEP = 2'b10,
        BOR_ON = 2'b11
    } bor_mode_t;
endpackage

//--- hw/pin_filter.sv
// synchroniser and low-pulse filter for the master clear pin
module pin_filter #(
    parameter int unsigned SAMPLES = rsc_pkg::FILTER_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_pin,
    output logic o_low,
    output logic o_level
);
    localparam int unsigned CNT_W = $clog2(SAMPLES + 1);
    localparam logic [CNT_W-1:0] CNT_TOP = CNT_W'(SAMPLES);
    logic meta_reg;
    logic [CNT_W-1:0] cnt_reg;

    // pin idles high through its pull-up
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_reg <= 1'b1;
            o_level <= 1'b1;
        end else begin
            meta_reg <= i_pin;
            o_level <= meta_reg;
        end
    end

    // low must persist for SAMPLES + 1 samples; any high sample restarts it
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_reg <= '0;
            o_low <= 1'b0;
        end else if (o_level) begin
            cnt_reg <= '0;
            o_low <= 1'b0;
        end else if (cnt_reg != CNT_TOP) begin
            cnt_reg <= cnt_reg + CNT_W'(1);
            o_low <= 1'b0;
        end else begin
            o_low <= 1'b1;
        end
    end
endmodule

//--- hw/power_up_timer.sv
// power-up delay counter, restarted while the hold input is high
module power_up_timer #(
    parameter int unsigned CYCLES = rsc_pkg::PUD_DEFAULT_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_hold,
    input wire logic i_power_up_delay_cfg_n,
    output logic o_running
);
    localparam int unsigned CNT_W = $clog2(CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLES);
    logic [CNT_W-1:0] cnt_reg;

    // loaded at power-on, reloaded while held, counts once released
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_reg <= CNT_LOAD;
        end else if (i_hold) begin
            cnt_reg <= CNT_LOAD;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - CNT_W'(1);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_running <= 1'b1;
        end else begin
            o_running <= !i_power_up_delay_cfg_n && (cnt_reg > CNT_W'(1));
        end
    end
endmodule

//--- bench/master_clear_pin_switch.sv
// board switch on the master clear pin, with the pin's weak pull-up
module master_clear_pin_switch (
    input wire logic i_press,
    input wire logic i_oe,
    input wire logic i_o,
    output logic o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // released pin floats up to the pull-up level
    assign o_pin = i_oe ? i_o : !i_press;
endmodule

//--- bench/reset_source_control_tb.sv
// self-checking bench for the reset source controller
module reset_source_control_tb;
    import rsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, press = 0, pin, po, poe, pull, gpio, srst_n;
    logic mcfg = 1, low_voltage_prog_cfg = 0, saw = 0, bor = 0, stk = 1, lpb = 0;
    bor_mode_t mode = BOR_ON;
    logic [4:0] ev = '0;
    logic [7:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rd;
    logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, awr, wr, bv, arr, rv;
    logic [1:0] br, rr;
    int n_fail = 0, check_count = 0, cyc = 0;
    always #4 clk = ~clk;
    master_clear_pin_switch SW (.i_press(press), .i_oe(poe), .i_o(po), .o_pin(pin));
    reset_source_control #(.PUD_CYCLES(40)) DUT (
        .i_clk_sys(clk), .i_reset_n(rst_n), .i_master_clear_pin(pin),
        .o_master_clear_pin_o(po), .o_master_clear_pin_oe(poe),
        .o_pin_pullup_en(pull), .o_pin_gpio_level(gpio),
        .i_master_clear_enable_cfg(mcfg), .i_low_voltage_prog_cfg(low_voltage_prog_cfg),
        .i_stack_fault_reset_cfg(stk), .i_power_up_delay_cfg_n(1'b0),
        .i_brownout_mode_cfg(mode), .i_sleeping(1'b0),
        .i_brownout_det(bor), .i_low_power_brownout_det(lpb),
        .i_watchdog_expire(ev[0]), .i_reset_instr(ev[1]),
        .i_stack_overflow(ev[2]), .i_stack_underflow(ev[3]),
        .i_prog_exit(ev[4]), .o_sys_reset_n(srst_n),
        .i_s_awaddr(awa), .i_s_awvalid(awv), .o_s_awready(awr),
        .i_s_wdata(wd), .i_s_wstrb(4'h1), .i_s_wvalid(wv),
        .o_s_wready(wr), .o_s_bresp(br), .o_s_bvalid(bv),
        .i_s_bready(bry), .i_s_araddr(ara), .i_s_arvalid(arv),
        .o_s_arready(arr), .o_s_rdata(rd), .o_s_rresp(rr),
        .o_s_rvalid(rv), .i_s_rready(rry));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (srst_n !== 1'b1)
            saw <= 1'b1;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        awa <= a;
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        forever begin
            @(posedge clk);
            if (awv && awr === 1'b1)
                awv <= 1'b0;
            if (wv && wr === 1'b1)
                wv <= 1'b0;
            if (bv === 1'b1)
                break;
        end
        bry <= 1'b0;
        chk("bresp", RESP_OKAY, br);
    endtask
    task automatic axr(input logic [7:0] a, input logic [7:0] e,
                       input logic [1:0] er);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        forever begin
            @(posedge clk);
            if (arv && arr === 1'b1)
                arv <= 1'b0;
            if (rv === 1'b1)
                break;
        end
        rry <= 1'b0;
        chk("rdata", {24'h0, e}, rd);
        chk("rresp", er, rr);
    endtask
    task automatic wait_up;
        for (int i = 0; i < 300 && srst_n !== 1'b1; i++)
            @(posedge clk);
        chk("sys_reset_n", 1, srst_n);
        saw <= 1'b0;
    endtask
    task automatic t_reset;
        wait_up();
        axr(BOR_CTRL_OFFSET, 8'h81, RESP_OKAY);
        axr(CAUSE_OFFSET, 8'h1e, RESP_OKAY);
        axr(8'h0c, 8'h00, RESP_SLVERR);
        chk("pin_oe", 0, poe);
        $display("test reset done");
    endtask
    task automatic t_events;
        logic [7:0] e;
        for (int k = 0; k < 5; k++) begin
            e = k == 0 ? 8'h0e : k == 1 ? 8'h1a : k == 2 ? 8'h9e :
                k == 3 ? 8'h5e : 8'h1e;
            @(posedge clk);
            ev <= 5'(1 << k);
            @(posedge clk);
            ev <= '0;
            @(posedge clk);
            #1 chk("sys_reset_n", 0, srst_n);
            wait_up();
            axr(CAUSE_OFFSET, e, RESP_OKAY);
            if (k == 0)
                axr(PIN_CTRL_OFFSET, 8'h0b, RESP_OKAY);
            axw(CAUSE_OFFSET, 8'h1e);
        end
        axw(CAUSE_OFFSET, 8'hc0);
        axr(CAUSE_OFFSET, 8'hc0, RESP_OKAY);
        chk("soft_flags_reset", 0, saw);
        axw(CAUSE_OFFSET, 8'h1e);
        stk <= 1'b0;
        @(posedge clk);
        ev <= 5'h04;
        @(posedge clk);
        ev <= '0;
        repeat (3) @(posedge clk);
        chk("stack_off_reset", 0, saw);
        axr(CAUSE_OFFSET, 8'h1e, RESP_OKAY);
        stk <= 1'b1;
        $display("test events done");
    endtask
    task automatic t_pin;
        for (int k = 0; k < 3; k++) begin
            {mcfg, low_voltage_prog_cfg} <= k == 0 ? 2'b10 : k == 1 ? 2'b01 : 2'b00;
            press <= 1'b1;
            repeat (4) @(posedge clk);
            press <= 1'b0;
            repeat (12) @(posedge clk);
            chk("short_pulse", 0, saw);
            press <= 1'b1;
            repeat (20) @(posedge clk);
            chk("gpio_level", 0, gpio);
            press <= 1'b0;
            wait_up();
            axr(CAUSE_OFFSET, k != 2 ? 8'h16 : 8'h1e, RESP_OKAY);
            axw(CAUSE_OFFSET, 8'h1e);
        end
        axw(PIN_CTRL_OFFSET, 8'h00);
        @(posedge clk);
        mcfg <= 1'b1;
        #1 chk("pullup_en", 0, pull);
        @(posedge clk);
        #1 chk("pullup_en", 1, pull);
        $display("test pin done");
    endtask
    task automatic t_bor;
        @(posedge clk);
        mode <= BOR_SOFT;
        axw(BOR_CTRL_OFFSET, 8'h00);
        axr(BOR_CTRL_OFFSET, 8'h00, RESP_OKAY);
        bor <= 1'b1;
        repeat (3) @(posedge clk);
        bor <= 1'b0;
        chk("soft_bor_off", 0, saw);
        axw(BOR_CTRL_OFFSET, 8'h80);
        axr(BOR_CTRL_OFFSET, 8'h81, RESP_OKAY);
        mode <= BOR_ON;
        axw(BOR_CTRL_OFFSET, 8'h00);
        axr(BOR_CTRL_OFFSET, 8'h01, RESP_OKAY);
        axw(BOR_CTRL_OFFSET, 8'h80);
        bor <= 1'b1;
        repeat (5) @(posedge clk);
        bor <= 1'b0;
        repeat (36) @(posedge clk);
        #1 chk("sys_reset_n", 0, srst_n);
        wait_up();
        axr(CAUSE_OFFSET, 8'h1c, RESP_OKAY);
        axw(CAUSE_OFFSET, 8'h1e);
        mode <= BOR_OFF;
        axr(BOR_CTRL_OFFSET, 8'h80, RESP_OKAY);
        bor <= 1'b1;
        repeat (3) @(posedge clk);
        bor <= 1'b0;
        chk("bor_off_reset", 0, saw);
        lpb <= 1'b1;
        repeat (3) @(posedge clk);
        lpb <= 1'b0;
        #1 chk("sys_reset_n", 0, srst_n);
        wait_up();
        axr(CAUSE_OFFSET, 8'h1c, RESP_OKAY);
        $display("test brownout done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (38) @(posedge clk);
        #1 chk("sys_reset_n", 0, srst_n);
        t_reset();
        t_events();
        t_pin();
        t_bor();
        complete_run();
    end
endmodule
